// file: hw/mds_sequencer.sv
// Dual-bank sequencer and shifting byte interface of a 40-bit accumulator.
// Assumes the host I/O strobes and the engine handshake run on clock;
// the multiply-accumulate engine itself lives outside.
`timescale 1ns/100ps

module mds_sequencer
  import mds_pkg::*;
(
  input  wire logic                 clock,          // System clock, 20 MHz
  input  wire logic                 resetn,         // Asynchronous reset, active low
  input  wire mds_io_req_t          io_req,         // Host I/O request
  output logic [7:0]                io_rdata_q,     // Read data, valid the cycle after rd
  input  wire logic                 calc_done,      // Engine pulse: running calculation over
  input  wire logic                 mac_acc_we,     // Engine writes the calc bank accumulator
  input  wire logic [MDS_ACC_W-1:0] mac_acc_val,    // Engine accumulator value
  output logic                      calc_start_q,   // Pulse: engine starts on calc bank
  output mds_stat_t                 stat_q,         // Bank status and bank selector
  output logic [7:0]                ctl_q,          // shift_control_reg contents
  output logic [MDS_ACC_W-1:0]      acc0_q,         // Physical bank 0 accumulator
  output logic [MDS_ACC_W-1:0]      acc1_q          // Physical bank 1 accumulator
);

  // ==========================================================
  // Byte lane helpers

  // Accumulator after a shifted byte write into lane k
  function automatic logic [MDS_ACC_W-1:0] acc_load(
    input logic [MDS_ACC_W-1:0] acc,
    input logic [2:0]           lane,
    input logic [2:0]           sh,
    input logic                 fill,
    input logic [7:0]           din
  );
    logic [47:0] pos;
    logic [47:0] val;
    logic [47:0] msk;
    logic [47:0] fmsk;
    pos  = 48'(lane) * 48'h8 + 48'(sh);
    val  = 48'(din) << pos;
    msk  = 48'hFF << pos;
    fmsk = (lane == 3'h0) ? ((48'h1 << sh) - 48'h1) : 48'h0;
    val  = val | (fill ? fmsk : 48'h0);
    msk  = msk | fmsk;
    // Bits shifted past 39 drop here, so the top lane keeps only 8-n bits
    return (acc & ~msk[MDS_ACC_W-1:0]) | (val[MDS_ACC_W-1:0] & msk[MDS_ACC_W-1:0]);
  endfunction

  // Byte k of the accumulator after an arithmetic right shift
  function automatic logic [7:0] acc_read(
    input logic [MDS_ACC_W-1:0] acc,
    input logic [2:0]           lane,
    input logic [2:0]           sh
  );
    logic signed [MDS_ACC_W-1:0] sacc;
    logic [5:0]                  pos;
    sacc = acc;
    pos  = 6'(lane) * 6'h8 + 6'(sh);
    return 8'(sacc >>> pos);
  endfunction

  // ==========================================================
  // Address decode of the host request
  wire logic [7:0] lo_addr   = io_req.addr[7:0];
  wire logic       is_final  = (io_req.addr[15:8] == MDS_FINAL_HI);
  wire logic       in_blk    = (lo_addr >= MDS_BLK_FIRST) && (lo_addr <= MDS_BLK_LAST);
  wire logic       hit_ctl   = (lo_addr == MDS_OFF_CTL);
  wire logic       hit_stat  = (lo_addr == MDS_OFF_STAT);
  wire logic       hit_acc   = (lo_addr >= MDS_OFF_ACC0) && (lo_addr <= MDS_OFF_ACC4);
  wire logic       hit_top   = (lo_addr == MDS_OFF_ACC4);
  wire logic [2:0] lane      = 3'(lo_addr - MDS_OFF_ACC0);
  wire logic [2:0] in_sh     = ctl_q[MDS_IN_SH_LSB +: 3];
  wire logic [2:0] out_sh    = ctl_q[MDS_OUT_SH_LSB +: 3];
  wire logic       fill_bit  = ctl_q[MDS_FILL_BIT];

  // ==========================================================
  // Sequencer events
  // A top byte write always counts; other lanes and control only when final
  wire logic def_done  = io_req.wr && (hit_top || (is_final && (hit_ctl || hit_acc)));
  wire logic rd_done   = io_req.rd && (hit_top || (is_final && hit_acc));
  wire logic wr_other  = io_req.wr && in_blk && !hit_stat;
  wire logic swap_cmd  = io_req.wr && hit_stat && (io_req.wdata == MDS_SWAP_CMD);
  wire logic calc_fin  = calc_done && (stat_q.exec_bank_state == MDS_C_BUSY);
  wire logic acc_clr   = io_req.wr && hit_ctl && is_final;

  // ==========================================================
  // Next bank state; each step sees the result of the one before
  logic [1:0] data_d;
  logic [1:0] calc_d;
  logic       swap_d;
  logic       start_d;

  always_comb begin
    data_d  = stat_q.data_stat;
    calc_d  = stat_q.exec_bank_state;
    swap_d  = 1'b0;
    start_d = 1'b0;
    // Consuming or overwriting an unread result
    if (data_d == MDS_D_DONE && (rd_done || wr_other)) begin
      data_d = MDS_D_EMPTY;
    end
    // Engine finished the running calculation
    if (calc_fin) begin
      if (data_d == MDS_D_READY) begin
        data_d  = MDS_D_DONE;
        swap_d  = 1'b1;
        start_d = 1'b1;
      end else begin
        calc_d = MDS_C_DONE;
      end
    end
    // A completed definition with an empty data bank
    if (def_done && data_d == MDS_D_EMPTY) begin
      unique case (calc_d)
        MDS_C_EMPTY: begin
          calc_d  = MDS_C_BUSY;
          swap_d  = 1'b1;
          start_d = 1'b1;
        end
        MDS_C_BUSY: begin
          data_d = MDS_D_READY;
        end
        default: begin
          data_d  = MDS_D_DONE;
          calc_d  = MDS_C_BUSY;
          swap_d  = 1'b1;
          start_d = 1'b1;
        end
      endcase
    end
    // Software-forced swap to expose a finished result
    if (swap_cmd && data_d == MDS_D_EMPTY && calc_d == MDS_C_DONE) begin
      data_d = MDS_D_DONE;
      calc_d = MDS_C_EMPTY;
      swap_d = 1'b1;
    end
  end

  // ==========================================================
  // Host-side accumulator and the engine's accumulator
  wire logic [MDS_ACC_W-1:0] data_acc = stat_q.data_bank ? acc1_q : acc0_q;
  wire logic                 acc_wr   = io_req.wr && hit_acc;
  wire logic [MDS_ACC_W-1:0] data_acc_d =
    acc_clr ? MDS_ACC_RESET :
    acc_wr  ? acc_load(data_acc, lane, in_sh, fill_bit, io_req.wdata) : data_acc;
  wire logic [MDS_ACC_W-1:0] calc_acc = stat_q.data_bank ? acc0_q : acc1_q;
  wire logic [MDS_ACC_W-1:0] calc_acc_d = mac_acc_we ? mac_acc_val : calc_acc;
  wire logic [MDS_ACC_W-1:0] acc0_d = stat_q.data_bank ? calc_acc_d : data_acc_d;
  wire logic [MDS_ACC_W-1:0] acc1_d = stat_q.data_bank ? data_acc_d : calc_acc_d;

  // ==========================================================
  // Read data mux; unmapped and other-block reads return zero
  wire logic [7:0] rd_val =
    hit_stat ? {4'h0, stat_q.exec_bank_state, stat_q.data_stat} :
    hit_ctl  ? ctl_q :
    hit_acc  ? acc_read(data_acc, lane, out_sh) : 8'h00;

  // State and bank selector; the swap is a flip of the selector
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stat_q       <= '{MDS_D_EMPTY, MDS_C_EMPTY, 1'b0};
      calc_start_q <= 1'b0;
    end else begin
      stat_q       <= '{data_d, calc_d, stat_q.data_bank ^ swap_d};
      calc_start_q <= start_d;
    end
  end

  // Control register and accumulators
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctl_q  <= MDS_CTL_RESET;
      acc0_q <= MDS_ACC_RESET;
      acc1_q <= MDS_ACC_RESET;
    end else begin
      ctl_q  <= (io_req.wr && hit_ctl) ? io_req.wdata : ctl_q;
      acc0_q <= acc0_d;
      acc1_q <= acc1_d;
    end
  end

  // Registered read data; holds between reads
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      io_rdata_q <= 8'h00;
    end else begin
      io_rdata_q <= io_req.rd ? rd_val : io_rdata_q;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  wire logic [1:0] ds = stat_q.data_stat;
  wire logic [1:0] cs = stat_q.exec_bank_state;
  wire logic       no_clear = !(wr_other && ds == MDS_D_DONE) && !rd_done;

  // Shifted read rebuilt from a sign-extended copy, not from the read function
  wire logic [47:0] acc_sx    = {{8{data_acc[MDS_ACC_W-1]}}, data_acc};
  wire logic [5:0]  rd_pos    = {lane, 3'h0} + {3'h0, out_sh};
  wire logic [7:0]  rd_expect = 8'(acc_sx >> rd_pos);
  wire logic [7:0]  fill_msk  = (8'h01 << in_sh) - 8'h01;

  sequence s_swap_start;
    stat_q.data_bank != $past(stat_q.data_bank) && calc_start_q;
  endsequence

  property p_both_empty_def;
    ds == MDS_D_EMPTY && cs == MDS_C_EMPTY && def_done && !swap_cmd
      |=> s_swap_start and (cs == MDS_C_BUSY && ds == MDS_D_EMPTY);
  endproperty
  a_both_empty_def: assert property (p_both_empty_def) else $error("def from empty");

  property p_queue_def;
    ds == MDS_D_EMPTY && cs == MDS_C_BUSY && def_done && !calc_done
      |=> ds == MDS_D_READY && $stable(stat_q.data_bank) && !calc_start_q;
  endproperty
  a_queue_def: assert property (p_queue_def) else $error("queued def wrong");

  property p_finish;
    cs == MDS_C_BUSY && calc_done && ds != MDS_D_READY && !def_done && no_clear
      |=> cs == MDS_C_DONE && ds == $past(ds) && !calc_start_q;
  endproperty
  a_finish: assert property (p_finish) else $error("finish wrong");

  property p_swap_cmd;
    ds == MDS_D_EMPTY && cs == MDS_C_DONE && swap_cmd
      |=> ds == MDS_D_DONE && cs == MDS_C_EMPTY && $changed(stat_q.data_bank);
  endproperty
  a_swap_cmd: assert property (p_swap_cmd) else $error("swap cmd wrong");

  property p_done_def;
    ds == MDS_D_EMPTY && cs == MDS_C_DONE && def_done
      |=> s_swap_start and (ds == MDS_D_DONE && cs == MDS_C_BUSY);
  endproperty
  a_done_def: assert property (p_done_def) else $error("def on done wrong");

  property p_auto_swap;
    ds == MDS_D_READY && cs == MDS_C_BUSY && calc_done
      |=> s_swap_start and (ds == MDS_D_DONE && cs == MDS_C_BUSY);
  endproperty
  a_auto_swap: assert property (p_auto_swap) else $error("auto swap wrong");

  property p_read_empties;
    ds == MDS_D_DONE && rd_done && !calc_done |=> ds == MDS_D_EMPTY && cs == $past(cs);
  endproperty
  a_read_empties: assert property (p_read_empties) else $error("read left data");

  property p_write_empties;
    ds == MDS_D_DONE && wr_other && !def_done && !calc_done |=> ds == MDS_D_EMPTY;
  endproperty
  a_write_empties: assert property (p_write_empties) else $error("write kept data");

  property p_hold;
    ds == MDS_D_DONE && !rd_done && !wr_other |=> ds == MDS_D_DONE;
  endproperty
  a_hold: assert property (p_hold) else $error("done data lost");

  // A top byte read empties done data even outside a block transfer
  property p_top_read;
    ds == MDS_D_DONE && io_req.rd && !io_req.wr && lo_addr == MDS_OFF_ACC4
      |=> ds == MDS_D_EMPTY;
  endproperty
  a_top_read: assert property (p_top_read) else $error("top read kept data");

  // A final control write leaves the old data accumulator cleared
  property p_ctl_clear;
    io_req.wr && is_final && lo_addr == MDS_OFF_CTL
      |=> ($past(stat_q.data_bank) ? acc1_q : acc0_q) == MDS_ACC_RESET;
  endproperty
  a_ctl_clear: assert property (p_ctl_clear) else $error("final ctl kept acc");

  // Vacated low bits of byte 0 take the fill bit
  property p_low_fill;
    io_req.wr && lo_addr == MDS_OFF_ACC0
      |=> ((($past(stat_q.data_bank) ? acc1_q[7:0] : acc0_q[7:0]) ^ {8{$past(fill_bit)}})
           & $past(fill_msk)) == 8'h00;
  endproperty
  a_low_fill: assert property (p_low_fill) else $error("fill bits wrong");

  property p_read_byte;
    io_req.rd && hit_acc && !io_req.wr |=> io_rdata_q == $past(rd_expect);
  endproperty
  a_read_byte: assert property (p_read_byte) else $error("shifted read wrong");

endmodule

// file: hw/mds_pkg.sv
// Package for the dual-bank accumulator sequencer.
// Assumes one system clock; the host I/O request is on that clock.
package mds_pkg;

  // ==========================================================
  // Register offsets within the 8-bit I/O page
  localparam logic [7:0] MDS_BLK_FIRST  = 8'hE0;  // First address owned by the block
  localparam logic [7:0] MDS_BLK_LAST   = 8'hEF;  // Last address owned by the block
  localparam logic [7:0] MDS_OFF_CTL    = 8'hE8;  // shift_control_reg
  localparam logic [7:0] MDS_OFF_ACC0   = 8'hE9;  // accum_byte_lowest
  localparam logic [7:0] MDS_OFF_ACC4   = 8'hED;  // accum_byte_top
  localparam logic [7:0] MDS_OFF_STAT   = 8'hEE;  // bank_status_reg

  // ==========================================================
  // Block transfer marker and commands
  localparam logic [7:0] MDS_FINAL_HI   = 8'h01;  // Upper address byte of the final transfer
  localparam logic [7:0] MDS_SWAP_CMD   = 8'h80;  // Status write that forces a swap

  // ==========================================================
  // Field positions of shift_control_reg
  localparam int         MDS_IN_SH_LSB  = 0;
  localparam int         MDS_OUT_SH_LSB = 3;
  localparam int         MDS_FILL_BIT   = 6;
  localparam logic [7:0] MDS_CTL_RESET  = 8'h00;

  // ==========================================================
  // Bank status codes
  localparam logic [1:0] MDS_D_EMPTY    = 2'h0;
  localparam logic [1:0] MDS_D_READY    = 2'h1;
  localparam logic [1:0] MDS_D_DONE     = 2'h3;
  localparam logic [1:0] MDS_C_EMPTY    = 2'h0;
  localparam logic [1:0] MDS_C_BUSY     = 2'h2;
  localparam logic [1:0] MDS_C_DONE     = 2'h3;

  localparam int         MDS_ACC_W      = 40;
  localparam logic [MDS_ACC_W-1:0] MDS_ACC_RESET = 40'h00_0000_0000;

  // ==========================================================
  // Host I/O request
  typedef struct packed {
    logic [15:0] addr;   // Full I/O address, upper byte is the block counter
    logic [7:0]  wdata;  // Write data
    logic        wr;     // One-cycle write strobe
    logic        rd;     // One-cycle read strobe
  } mds_io_req_t;

  // Sequencer status seen by the engine
  typedef struct packed {
    logic [1:0] data_stat;  // DATA bank status
    logic [1:0] exec_bank_state;  // CALC bank status
    logic       data_bank;  // Physical bank now seen by the host
  } mds_stat_t;

endpackage

// file: dv/mds_host_model.sv
// Host model: the CPU side that issues single I/O writes and reads.
// Assumes the bench calls its tasks; strobes change on the falling edge.
`timescale 1ns/100ps
module mds_host_model
  import mds_pkg::*;
(
  input  wire logic       clock,   // System clock
  output mds_io_req_t     io_req,  // Request to the block
  input  wire logic [7:0] rdata    // Registered read data
);
  // ==========================================================
  // Bus cycles
  // Released lines show the inverse of the last value, so nothing stale matches
  initial io_req = '0;

  // One write; upper byte 01h only where a bank change is wanted
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    io_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clock);
    io_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  // One read; data is taken one edge after the strobe
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock);
    io_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clock);
    d = rdata;
    io_req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
  endtask
endmodule

// file: dv/tb_top.sv
// Testbench for the dual-bank accumulator sequencer.
// Assumes one 20 MHz clock; the engine side is driven by the bench.
`timescale 1ns/100ps
module tb_top
  import mds_pkg::*;
;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        calc_done = 1'b0;
  logic        mac_acc_we = 1'b0;
  logic [39:0] mac_acc_val = 40'h00_0000_0000;
  logic [7:0]  io_rdata_q;
  logic [7:0]  ctl_q;
  logic        calc_start_q;
  mds_stat_t   stat_q;
  logic [39:0] acc0_q;
  logic [39:0] acc1_q;
  mds_io_req_t io_req;
  int          n_mismatch = 0;
  int          n_checks = 0;

  // ==========================================================
  // Clock and instances
  always #25 clock = ~clock;

  mds_sequencer uut (.clock(clock), .resetn(resetn), .io_req(io_req),
    .io_rdata_q(io_rdata_q), .calc_done(calc_done), .mac_acc_we(mac_acc_we),
    .mac_acc_val(mac_acc_val), .calc_start_q(calc_start_q), .stat_q(stat_q),
    .ctl_q(ctl_q), .acc0_q(acc0_q), .acc1_q(acc1_q));

  mds_host_model host (.clock(clock), .io_req(io_req), .rdata(io_rdata_q));

  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Status is read over the bus as {0000, calc, data}
  task automatic st(input logic [3:0] exp);
    logic [7:0] v;
    host.io_rd({8'h00, MDS_OFF_STAT}, v);
    chk(40'(v), 40'({4'h0, exp}));
  endtask

  // Engine leaves its result in the calc bank, then signals the finish
  task automatic pulse_done(input logic [39:0] res);
    @(negedge clock);
    mac_acc_we  = 1'b1;
    mac_acc_val = res;
    @(negedge clock);
    mac_acc_we = 1'b0;
    calc_done  = 1'b1;
    @(negedge clock) calc_done = 1'b0;
  endtask

  // Writes all five bytes under a shift setting, then reads them back
  task automatic load_acc(input logic [7:0] ctl, input logic [39:0] v);
    logic [39:0] e;
    logic [39:0] r;
    logic [7:0]  b;
    e = (v << ctl[2:0]) | (((40'h1 << ctl[2:0]) - 40'h1) & {40{ctl[6]}});
    r = $signed(e) >>> ctl[5:3];
    host.io_wr({8'h00, MDS_OFF_CTL}, ctl);
    for (int k = 0; k < 5; k++) host.io_wr({8'h00, MDS_OFF_ACC0 + 8'(k)}, v[8*k +: 8]);
    chk(stat_q.data_bank ? acc1_q : acc0_q, e);
    for (int k = 0; k < 5; k++) begin
      host.io_rd({8'h00, MDS_OFF_ACC0 + 8'(k)}, b);
      chk(40'(b), 40'(r[8*k +: 8]));
    end
    st(4'h9);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_define();
    st(4'h0);
    chk(40'(ctl_q), 40'(MDS_CTL_RESET));
    host.io_wr({MDS_FINAL_HI, MDS_OFF_CTL}, 8'h00);
    chk(40'(calc_start_q), 40'h1);
    st(4'h8);
    $display("t_define done");
  endtask

  // Negative top byte checks sign fill under a right shift
  task automatic t_shift();
    logic [7:0] b;
    load_acc(8'h5B, 40'h95_A3_5C_E1_27);
    pulse_done(40'hC0_0000_0000);
    chk(40'(calc_start_q), 40'h1);
    st(4'hB);
    host.io_rd({8'h00, MDS_OFF_ACC4}, b);
    chk(40'(b), 40'h00_0000_00F8);
    st(4'h8);
    load_acc(8'h00, 40'h81_7E_C3_3C_18);
    $display("t_shift done");
  endtask

  // Walks the remaining bank transitions, refusals included
  task automatic t_bank();
    logic [7:0] b;
    pulse_done(40'h00_0000_0000);
    st(4'hB);
    host.io_wr(16'h00E0, 8'h5A);
    st(4'h8);
    pulse_done(40'h55_6677_8899);
    st(4'hC);
    host.io_wr({MDS_FINAL_HI, MDS_OFF_ACC0 + 8'h02}, 8'h11);
    st(4'hB);
    pulse_done(40'h12_3456_789A);
    st(4'hF);
    host.io_wr({8'h00, MDS_OFF_STAT}, MDS_SWAP_CMD);
    host.io_rd({8'h00, MDS_OFF_ACC0 + 8'h01}, b);
    chk(40'(b), 40'h00_0000_0088);
    st(4'hF);
    host.io_rd({MDS_FINAL_HI, MDS_OFF_ACC0}, b);
    st(4'hC);
    host.io_wr({8'h00, MDS_OFF_STAT}, MDS_SWAP_CMD);
    st(4'h3);
    host.io_rd({8'h00, MDS_OFF_ACC0 + 8'h03}, b);
    chk(40'(b), 40'h00_0000_0034);
    host.io_wr({MDS_FINAL_HI, MDS_OFF_CTL}, 8'h00);
    st(4'h8);
    chk(stat_q.data_bank ? acc0_q : acc1_q, MDS_ACC_RESET);
    $display("t_bank done");
  endtask

  // Reset in mid-run returns every bank and register to idle
  task automatic t_reset();
    host.io_wr({8'h00, MDS_OFF_CTL}, 8'h5B);
    @(negedge clock) resetn = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    chk(40'(ctl_q), 40'(MDS_CTL_RESET));
    chk(40'(stat_q.data_bank), 40'h0);
    chk(40'(calc_start_q), 40'h0);
    chk(acc0_q | acc1_q, MDS_ACC_RESET);
    st(4'h0);
    $display("t_reset done");
  endtask

  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    t_define();
    t_shift();
    t_bank();
    t_reset();
    print_verdict();
  end

  // Run needs about 125 cycles; a hang stops at 5000 cycles, well after that
  initial begin
    #(50 * 5000);
    n_mismatch++;
    print_verdict();
  end
endmodule
